// *** rtl/rss_top.sv ***
`timescale 1ns/10ps
module rss_top #(
  parameter int unsigned ADC_W          = rss_pkg::ADC_W,
  parameter int unsigned FIFO_DEPTH     = rss_pkg::FIFO_DEPTH,
  parameter int unsigned FAST_TICK_CYC  = rss_pkg::FAST_TICK_CYC,
  parameter int unsigned SLOW_TICK_CYC  = rss_pkg::SLOW_TICK_CYC,
  parameter int unsigned EXC_PERIOD_CYC = rss_pkg::EXC_PERIOD_CYC
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // scan control
  input  wire logic               scan_start,
  input  wire logic               scan_stop,
  input  wire logic [ADC_W-1:0]   ref_excitation,
  output logic                    scan_running,
  // converter
  output logic                    adc_hold,
  output logic                    adc_start,
  output logic [1:0]              adc_chan,
  input  wire logic               adc_done,
  input  wire logic [ADC_W-1:0]   adc_data,
  // scan completion
  output logic                    scan_done_flag,
  output logic                    scan_done_irq,
  input  wire logic               scan_done_clear,
  // held capture
  output logic [ADC_W-1:0]        excitation_last,
  output logic [ADC_W-1:0]        sine_capture,
  output logic [ADC_W-1:0]        cosine_capture,
  output logic                    position_valid,
  // capture stream
  output logic                    cap_valid,
  input  wire logic               cap_ready,
  output logic [2*ADC_W-1:0]      cap_data,
  // periodic ticks
  output logic                    fast_position_tick,
  output logic                    slow_direction_tick,
  output logic                    rotation_dir
);

  localparam int unsigned CNT_W = rss_pkg::CNT_W;

  typedef struct packed {
    rss_pkg::rss_scan_t state;
    logic [1:0]         chan;
    logic [ADC_W-1:0]   exc;
    logic [ADC_W-1:0]   sin;
    logic [ADC_W-1:0]   cos;
    logic [ADC_W-1:0]   cap_sin;
    logic [ADC_W-1:0]   cap_cos;
    logic               running;
    logic               done_flag;
    logic               first_cap;
    logic [CNT_W-1:0]   holdoff;
    logic [CNT_W-1:0]   fast_cnt;
    logic [CNT_W-1:0]   slow_cnt;
    logic [2:0]         slow_num;
    logic               dir;
    logic               fast_tick;
    logic               slow_tick;
  } rss_top_state_t;

  rss_top_state_t s_q;
  rss_top_state_t s_d;
  logic           qualify;
  logic           fifo_in_ready;
  logic           fifo_in_valid;

  // capture condition on the finished scan
  assign qualify       = (s_q.exc == ref_excitation) && (s_q.holdoff == '0);
  assign fifo_in_valid = (s_q.state == rss_pkg::RSS_END) && qualify;

  rss_fifo #(
    .W     (2*ADC_W),
    .DEPTH (FIFO_DEPTH)
  ) rss_fifo_inst (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({s_q.sin, s_q.cos}),
    .out_valid (cap_valid),
    .out_ready (cap_ready),
    .out_data  (cap_data)
  );

  always_comb begin
    s_d           = s_q;
    s_d.fast_tick = 1'b0;
    s_d.slow_tick = 1'b0;

    // run control
    if (scan_stop) begin
      s_d.running = 1'b0;
    end else if (scan_start) begin
      s_d.running = 1'b1;
    end

    if (s_q.holdoff != '0) begin
      s_d.holdoff = s_q.holdoff - CNT_W'(1);
    end

    unique case (s_q.state)
      rss_pkg::RSS_IDLE: begin
        if (s_q.running) begin
          s_d.state = rss_pkg::RSS_HOLD;
        end
      end
      rss_pkg::RSS_HOLD: begin
        s_d.chan  = rss_pkg::CH_EXCITATION;
        s_d.state = rss_pkg::RSS_REQ;
      end
      rss_pkg::RSS_REQ: begin
        s_d.state = rss_pkg::RSS_WAIT;
      end
      rss_pkg::RSS_WAIT: begin
        if (adc_done) begin
          if (s_q.chan == rss_pkg::CH_EXCITATION) begin
            s_d.exc = adc_data;
          end else if (s_q.chan == rss_pkg::CH_SINE) begin
            s_d.sin = adc_data;
          end else begin
            s_d.cos = adc_data;
          end
          if (s_q.chan == rss_pkg::CH_COSINE) begin
            s_d.state = rss_pkg::RSS_END;
          end else begin
            s_d.chan  = s_q.chan + 2'h1;
            s_d.state = rss_pkg::RSS_REQ;
          end
        end
      end
      rss_pkg::RSS_END: begin
        if (!(qualify && !fifo_in_ready)) begin
          if (qualify) begin
            s_d.cap_sin   = s_q.sin;
            s_d.cap_cos   = s_q.cos;
            s_d.first_cap = 1'b1;
            s_d.holdoff   = CNT_W'(EXC_PERIOD_CYC) - CNT_W'(1);
          end
          s_d.state = s_d.running ? rss_pkg::RSS_HOLD : rss_pkg::RSS_IDLE;
        end
      end
    endcase

    // scan end sets the flag, set wins over clear
    if (scan_done_clear) begin
      s_d.done_flag = 1'b0;
    end
    if (s_q.state == rss_pkg::RSS_END && !(qualify && !fifo_in_ready)) begin
      s_d.done_flag = 1'b1;
    end

    // fast tick
    if (s_q.fast_cnt == CNT_W'(FAST_TICK_CYC - 1)) begin
      s_d.fast_cnt  = '0;
      s_d.fast_tick = s_q.first_cap;
    end else begin
      s_d.fast_cnt = s_q.fast_cnt + CNT_W'(1);
    end

    // slow tick and direction
    if (s_q.slow_cnt == CNT_W'(SLOW_TICK_CYC - 1)) begin
      s_d.slow_cnt  = '0;
      s_d.slow_tick = 1'b1;
      if (s_q.slow_num == 3'(rss_pkg::SLOW_TICKS_FLIP - 1)) begin
        s_d.slow_num = '0;
        s_d.dir      = ~s_q.dir;
      end else begin
        s_d.slow_num = s_q.slow_num + 3'h1;
      end
    end else begin
      s_d.slow_cnt = s_q.slow_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q       <= '0;
      s_q.state <= rss_pkg::RSS_IDLE;
      s_q.dir   <= rss_pkg::DIR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign scan_running        = s_q.running;
  assign adc_hold            = (s_q.state == rss_pkg::RSS_HOLD);
  assign adc_start           = (s_q.state == rss_pkg::RSS_REQ);
  assign adc_chan            = s_q.chan;
  assign scan_done_flag      = s_q.done_flag;
  assign scan_done_irq       = s_q.done_flag;
  assign excitation_last     = s_q.exc;
  assign sine_capture        = s_q.cap_sin;
  assign cosine_capture      = s_q.cap_cos;
  assign position_valid      = s_q.first_cap;
  assign fast_position_tick  = s_q.fast_tick;
  assign slow_direction_tick = s_q.slow_tick;
  assign rotation_dir        = s_q.dir;

endmodule : rss_top

// *** common/rss_pkg.sv ***
// Notes on behaviour
// - excitation, sine, cosine held at one instant, then converted one after another.
// - once started, scans repeat without further starts until stopped.
// - after the third channel of a scan, a completion interrupt is raised.
// - fast tick every 50 us paces position evaluation and drive update.
// - slow tick every 0.8 s; direction inverts after every fifth slow tick.
// - sine/cosine captured only when excitation result equals the reference.
// - at most one sine/cosine capture per 900 us excitation cycle.
// - capture resolution is fine enough for 30-degree rotor sectors.
// - scan end sets the done flag and interrupt; the handler clears it.
// - fast position tick is enabled only after the first capture.
package rss_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned FAST_TICK_NS     = 50_000;
  localparam int unsigned FAST_TICK_CYC    = FAST_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOW_TICK_MS     = 800;
  localparam longint unsigned SLOW_TICK_NS = longint'(SLOW_TICK_MS) * 64'd1_000_000;
  localparam int unsigned SLOW_TICK_CYC    = 32'(SLOW_TICK_NS / CLK_PERIOD_NS);
  localparam int unsigned EXC_PERIOD_NS    = 900_000;
  localparam int unsigned EXC_PERIOD_CYC   = EXC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOW_TICKS_FLIP  = 5;

  localparam int unsigned ADC_W            = 10;
  localparam int unsigned FIFO_DEPTH       = 16;
  localparam int unsigned CNT_W            = 32;

  localparam logic [1:0]  CH_EXCITATION    = 2'h0;
  localparam logic [1:0]  CH_SINE          = 2'h1;
  localparam logic [1:0]  CH_COSINE        = 2'h2;

  localparam logic        DIR_RESET        = 1'h0;

  typedef enum logic [2:0] {
    RSS_IDLE,
    RSS_HOLD,
    RSS_REQ,
    RSS_WAIT,
    RSS_END
  } rss_scan_t;

endpackage : rss_pkg

// *** rtl/rss_fifo.sv ***
`timescale 1ns/10ps
module rss_fifo #(
  parameter int unsigned W     = 20,
  parameter int unsigned DEPTH = rss_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             count;
  } rss_fifo_state_t;

  rss_fifo_state_t s_q;
  rss_fifo_state_t s_d;
  logic            push;
  logic            pop;

  assign in_ready  = (s_q.count != (AW+1)'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data  = s_q.mem[s_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + AW'(1);
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + AW'(1);
    end
    if (push && !pop) begin
      s_d.count = s_q.count + (AW+1)'(1);
    end else if (pop && !push) begin
      s_d.count = s_q.count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : rss_fifo

// *** test/rss_adc_model.sv ***
`timescale 1ns/10ps
module rss_adc_model #(
  parameter int unsigned W = 10
) (
  // converter control
  input  wire logic         clk,
  input  wire logic         adc_hold,
  input  wire logic         adc_start,
  input  wire logic [1:0]   adc_chan,
  // analog levels
  input  wire logic [W-1:0] exc_val,
  input  wire logic [W-1:0] sin_val,
  input  wire logic [W-1:0] cos_val,
  // result
  output logic              adc_done,
  output logic [W-1:0]      adc_data
);
  logic [1:0]   ch_q;
  logic [2:0]   cnt_q  = 3'h0;
  logic [W-1:0] last_q = '0;
  logic [W-1:0] exc_q;
  logic [W-1:0] sin_q;
  logic [W-1:0] cos_q;
  logic [W-1:0] v;
  initial adc_done = 1'b0;
  // held levels picked per channel, unknown until the first hold
  assign v = (ch_q == 2'h0) ? exc_q : (ch_q == 2'h1) ? sin_q : cos_q;
  always @(posedge clk) begin
    adc_done <= 1'b0;
    adc_data <= ~last_q;
    if (adc_hold) begin
      exc_q <= exc_val;
      sin_q <= sin_val;
      cos_q <= cos_val;
    end
    if (adc_start) begin
      ch_q  <= adc_chan;
      cnt_q <= 3'h3;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h1) begin
        adc_done <= 1'b1;
        adc_data <= v;
        last_q   <= v;
      end
    end
  end
endmodule : rss_adc_model

// *** test/rss_assertions.sv ***
`timescale 1ns/10ps
module rss_checker #(
  parameter int unsigned ADC_W = 10
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             rst_b,
  // scan
  input wire logic             scan_start,
  input wire logic             scan_stop,
  input wire logic             scan_running,
  input wire logic             adc_hold,
  input wire logic             adc_start,
  input wire logic [1:0]       adc_chan,
  input wire logic             scan_done_flag,
  input wire logic             scan_done_irq,
  input wire logic             scan_done_clear,
  // capture
  input wire logic [ADC_W-1:0] ref_excitation,
  input wire logic [ADC_W-1:0] excitation_last,
  input wire logic [ADC_W-1:0] sine_capture,
  input wire logic             position_valid,
  // ticks
  input wire logic             fast_position_tick,
  input wire logic             slow_direction_tick,
  input wire logic             rotation_dir
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_hold_then_start: assert property (adc_hold |=> adc_start && adc_chan == rss_pkg::CH_EXCITATION)
    else $error("no start after hold");
  chk_run_after_start: assert property (scan_start && !scan_stop |=> scan_running)
    else $error("not running after start");
  chk_irq_equals_flag: assert property (scan_done_irq == scan_done_flag)
    else $error("irq differs from flag");
  chk_done_after_cos: assert property ($rose(scan_done_flag) |-> adc_chan == rss_pkg::CH_COSINE)
    else $error("flag raised before third channel");
  chk_flag_sticky: assert property (scan_done_flag && !scan_done_clear |=> scan_done_flag)
    else $error("flag lost without clear");
  chk_capture_match: assert property ($changed(sine_capture) |-> excitation_last == ref_excitation)
    else $error("capture without match");
  chk_capture_spaced: assert property ($changed(sine_capture) |=> $stable(sine_capture) [*8])
    else $error("captures too close");
  chk_fast_gated: assert property (fast_position_tick |-> position_valid)
    else $error("fast tick before capture");
  chk_fast_single: assert property (fast_position_tick |=> !fast_position_tick [*8])
    else $error("fast ticks too close");
  chk_dir_on_tick: assert property ($changed(rotation_dir) |-> slow_direction_tick)
    else $error("direction flip off tick");
  cov_first_capture: cover property ($rose(position_valid));
  cov_dir_flip: cover property ($changed(rotation_dir));
  cov_scan_stop: cover property ($fell(scan_running));
endmodule : rss_checker
bind rss_top rss_checker #(.ADC_W(ADC_W)) rss_checker_inst (
  .clk(clk), .rst_b(rst_b), .scan_start(scan_start), .scan_stop(scan_stop), .scan_running(scan_running),
  .adc_hold(adc_hold), .adc_start(adc_start), .adc_chan(adc_chan), .scan_done_flag(scan_done_flag),
  .scan_done_irq(scan_done_irq), .scan_done_clear(scan_done_clear), .ref_excitation(ref_excitation),
  .excitation_last(excitation_last), .sine_capture(sine_capture), .position_valid(position_valid),
  .fast_position_tick(fast_position_tick), .slow_direction_tick(slow_direction_tick), .rotation_dir(rotation_dir));

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned W   = rss_pkg::ADC_W;
  localparam int unsigned FT  = 20;
  localparam int unsigned ST  = 50;
  localparam int unsigned EP  = 40;
  localparam logic [W-1:0] REF = 10'h2a5;
  logic          clk, rst_b, scan_start, scan_stop, scan_done_clear, cap_ready, adc_done, adc_hold, adc_start;
  logic          scan_running, scan_done_flag, scan_done_irq, position_valid, cap_valid;
  logic          fast_position_tick, slow_direction_tick, rotation_dir;
  logic [1:0]    adc_chan;
  logic [W-1:0]  exc_val, sin_val, cos_val, adc_data, excitation_last, sine_capture, cosine_capture;
  logic [2*W-1:0] cap_data;
  int            err_total, samples_checked;
  rss_top #(.FAST_TICK_CYC(FT), .SLOW_TICK_CYC(ST), .EXC_PERIOD_CYC(EP)) rss_top_inst (
    .clk(clk), .rst_b(rst_b), .scan_start(scan_start), .scan_stop(scan_stop), .ref_excitation(REF),
    .scan_running(scan_running), .adc_hold(adc_hold), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_data(adc_data), .scan_done_flag(scan_done_flag), .scan_done_irq(scan_done_irq),
    .scan_done_clear(scan_done_clear), .excitation_last(excitation_last), .sine_capture(sine_capture),
    .cosine_capture(cosine_capture), .position_valid(position_valid), .cap_valid(cap_valid),
    .cap_ready(cap_ready), .cap_data(cap_data), .fast_position_tick(fast_position_tick),
    .slow_direction_tick(slow_direction_tick), .rotation_dir(rotation_dir));
  rss_adc_model #(.W(W)) rss_adc_model_inst (.clk(clk), .adc_hold(adc_hold), .adc_start(adc_start), .adc_chan(adc_chan),
    .exc_val(exc_val), .sin_val(sin_val), .cos_val(cos_val), .adc_done(adc_done), .adc_data(adc_data));
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp(input logic [2*W-1:0] got, input logic [2*W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // waits for scan end, then clears the flag
  task automatic wait_flag();
    int n;
    n = 0;
    while (scan_done_flag !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    cmp(n < 200, 1'b1);
    cmp(scan_done_irq, 1'b1);
    scan_done_clear = 1'b1;
    tick();
    scan_done_clear = 1'b0;
  endtask : wait_flag
  task automatic t_reset();
    int n;
    n = 0;
    cmp({scan_running, scan_done_flag, position_valid, rotation_dir, cap_valid}, 5'h00);
    repeat (3 * FT) begin
      tick();
      n += fast_position_tick;
    end
    cmp(n, 0);
  endtask : t_reset
  task automatic t_capture();
    scan_start = 1'b1;
    tick();
    scan_start = 1'b0;
    wait_flag();
    cmp(scan_done_flag, 1'b0);
    cmp({sine_capture, cosine_capture}, {10'h151, 10'h0a2});
    cmp(position_valid, 1'b1);
    sin_val = 10'h0c3;
    wait_flag();
    cmp(sine_capture, 10'h151);
    exc_val = REF + 10'h001;
    repeat (EP) tick();
    wait_flag();
    wait_flag();
    cmp(sine_capture, 10'h151);
    cmp(excitation_last, REF + 10'h001);
    exc_val = REF;
  endtask : t_capture
  task automatic t_ticks();
    int f, s, d;
    logic r;
    f = 0;
    s = 0;
    d = 0;
    r = rotation_dir;
    repeat (10 * ST) begin
      tick();
      f += fast_position_tick;
      s += slow_direction_tick;
      d += (rotation_dir !== r);
      r = rotation_dir;
    end
    cmp(f, 10 * ST / FT);
    cmp(s, 10);
    cmp(d, 2);
    cmp({sine_capture, cosine_capture}, {10'h0c3, 10'h0a2});
  endtask : t_ticks
  task automatic t_fifo();
    int n;
    n = 0;
    repeat (30 * EP) tick();
    scan_stop = 1'b1;
    tick();
    scan_stop = 1'b0;
    cap_ready = 1'b1;
    cmp(cap_data, {10'h151, 10'h0a2});
    repeat (100) begin
      n += (cap_valid === 1'b1);
      tick();
    end
    cmp(n, rss_pkg::FIFO_DEPTH + 1);
    cmp(scan_running, 1'b0);
  endtask : t_fifo
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  initial begin
    {rst_b, scan_start, scan_stop, scan_done_clear, cap_ready} = 5'h00;
    exc_val = REF;
    sin_val = 10'h151;
    cos_val = 10'h0a2;
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_capture();
    t_ticks();
    t_fifo();
    finish_test();
  end
endmodule : tb_top
